// >>> shared/hrd_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef HRD_REGS_SVH
`define HRD_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define HRD_OFS_CTRL        8'h00
`define HRD_OFS_RATIO2      8'h04
`define HRD_OFS_RATIO5      8'h08
`define HRD_OFS_XLIMIT      8'h0c
`define HRD_OFS_REF_CUR     8'h10
`define HRD_OFS_MIN_DIFF    8'h14
`define HRD_OFS_STATUS      8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HRD_CTRL_XBLK_EN    0
`define HRD_CTRL_FREQ60     1

// ----------------------------------------------------------------
// Reset values and setting ranges
// ----------------------------------------------------------------
`define HRD_RST_RATIO2      6'h0f
`define HRD_RST_RATIO5      6'h19
`define HRD_RATIO_MIN       6'h05
`define HRD_RATIO_MAX       6'h32
`define HRD_RST_XLIMIT      16'h1388
`define HRD_XLIMIT_MIN      16'h0064
`define HRD_XLIMIT_MAX      16'hea60
`define HRD_RST_REF_CUR     16'h0400
`define HRD_RST_MIN_DIFF    16'h0080

// ----------------------------------------------------------------
// Timing and thresholds
// ----------------------------------------------------------------
`define HRD_CLK_PERIOD_NS   25
`define HRD_MS_TICK_US      1000
`define HRD_CYC60_TICK_NS   833333
`define HRD_PICKUP_TICKS    5'd25
`define HRD_DROP_TICKS      5'd15
`define HRD_INRUSH_TICKS    13'd5000
`define HRD_EXT_ANGLE_DEG   9'd75
`define HRD_VALID_PCT       16'd10
`define HRD_INRUSH_PCT      16'd2

`endif

// >>> shared/hrd_pkg.sv
// Types shared by the harmonic restraint decision block
package hrd_pkg;

  // Per-element restraint sequence
  typedef enum logic [1:0] {
    HRD_IDLE   = 2'b00,
    HRD_PICKUP = 2'b01,
    HRD_HELD   = 2'b10,
    HRD_DROP   = 2'b11
  } hrd_elem_state_type;

endpackage

// >>> logic/hrd_restraint.sv
// Harmonic restraint decision with cross blocking and magnitude stage
//
// Contract
// - Angle difference of 75 degrees flags external fault
// - Angle valid only above 10% of reference
// - Three identical second-harmonic elements, one per phase
// - High ratio restrains at once, starts pickup
// - Continuous pickup time arms the drop-off extension
// - Sixty hertz uses the shorter drop-off time
// - Fifty hertz extends restraint by fixed drop-off
// - Second harmonic restrains only during inrush/external fault
// - OR of phase second-harmonic restraints into summary
// - Fifth harmonic uses same logic, minimum current only
// - Cross-block off: each element blocked by itself
// - Cross-block on: any restraint blocks all elements
// - Cross blocking ends at limit, self-blocking stays
// - Cross-block enable defaults true, limited duration
// - Cross-block limit 100 to 60000 ms, default 5000
// - Compute current magnitudes from sampled components
// - Ratio settings 5 to 50 percent, defaults 15/25
// - Inrush condition drops after fixed delay
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`include "hrd_regs.svh"

module hrd_restraint
#(
  parameter int MS_TICK_CYCLES =
    `HRD_MS_TICK_US * 1000 / `HRD_CLK_PERIOD_NS,
  parameter int CYC60_TICK_CYCLES =
    `HRD_CYC60_TICK_NS / `HRD_CLK_PERIOD_NS
)
(
  // Clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               rst_b_in,
  // Register port
  input  wire logic [7:0]         reg_addr_in,
  input  wire logic [15:0]        reg_wr_data_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic      [15:0]        reg_rd_data_out,
  // Sampled orthogonal components: 0-2 diff, 3-5 side one, 6-8 side two
  input  wire logic [8:0][15:0]   sample_re_in,
  input  wire logic [8:0][15:0]   sample_im_in,
  // Fourier magnitudes of the differential currents per phase
  input  wire logic [2:0][15:0]   fund_mag_in,
  input  wire logic [2:0][15:0]   second_mag_in,
  input  wire logic [2:0][15:0]   fifth_mag_in,
  // Phase-shifted current angles in degrees, 0 to 359
  input  wire logic [2:0][8:0]    side1_angle_in,
  input  wire logic [2:0][8:0]    side2_angle_in,
  // Magnitudes
  output logic      [8:0][15:0]   current_mag_out,
  // Restraint status
  output logic      [2:0]         second_harmonic_detect_out,
  output logic      [2:0]         second_harmonic_restraint_out,
  output logic                    any_phase_second_harmonic_restraint_out,
  output logic      [2:0]         fifth_harmonic_restraint_out,
  output logic                    any_phase_fifth_harmonic_restraint_out,
  output logic      [2:0]         element_block_out,
  output logic                    cross_block_active_out,
  output logic                    inrush_condition_out,
  output logic                    external_fault_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (MS_TICK_CYCLES < 2 || CYC60_TICK_CYCLES < 2 ||
      MS_TICK_CYCLES > 65535 || CYC60_TICK_CYCLES > 65535)
  begin : g_bad_tick
    $error("tick divider counts must lie in 2 to 65535");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Magnitude estimate max + min/2 of absolute components
  function automatic logic [15:0] mag_est(input logic [15:0] re,
                                          input logic [15:0] im);
    logic [15:0] a;
    logic [15:0] b;
    logic [16:0] s;
    a = re[15] ? 16'(-re) : re;
    b = im[15] ? 16'(-im) : im;
    if (a >= b)
      s = {1'b0, a} + {2'b00, b[15:1]};
    else
      s = {1'b0, b} + {2'b00, a[15:1]};
    mag_est = s[16] ? 16'hffff : s[15:0];
  endfunction

  // Harmonic above setting: harm*100 > setting*fund
  function automatic logic ratio_high(input logic [15:0] harm,
                                      input logic [15:0] fund,
                                      input logic [5:0]  setting);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(harm) * 24'd100;
    rhs = 24'(setting) * 24'(fund);
    ratio_high = (fund != 16'h0000) && (lhs > rhs);
  endfunction

  // Magnitude above pct percent of the reference current
  function automatic logic above_pct(input logic [15:0] mag,
                                     input logic [15:0] ref_cur,
                                     input logic [15:0] pct);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(mag) * 24'd100;
    rhs = 24'(ref_cur) * 24'(pct);
    above_pct = lhs > rhs;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic        xblk_en_q;
  logic        freq60_q;
  logic [5:0]  ratio2_q;
  logic [5:0]  ratio5_q;
  logic [15:0] xlimit_q;
  logic [15:0] ref_cur_q;
  logic [15:0] min_diff_q;
  logic        wr_ctrl;
  logic        wr_xlimit;

  assign wr_ctrl   = reg_wr_in && (reg_addr_in == `HRD_OFS_CTRL);
  assign wr_xlimit = reg_wr_in && (reg_addr_in == `HRD_OFS_XLIMIT);

  // Control register; enable defaults true so cross blocking is armed
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      xblk_en_q <= 1'b1;
      freq60_q  <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      xblk_en_q <= reg_wr_data_in[`HRD_CTRL_XBLK_EN];
      freq60_q  <= reg_wr_data_in[`HRD_CTRL_FREQ60];
    end
  end

  // Settings; out-of-range writes are ignored so the old value stands
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      ratio2_q   <= `HRD_RST_RATIO2;
      ratio5_q   <= `HRD_RST_RATIO5;
      xlimit_q   <= `HRD_RST_XLIMIT;
      ref_cur_q  <= `HRD_RST_REF_CUR;
      min_diff_q <= `HRD_RST_MIN_DIFF;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `HRD_OFS_RATIO2 &&
          reg_wr_data_in >= 16'(`HRD_RATIO_MIN) &&
          reg_wr_data_in <= 16'(`HRD_RATIO_MAX))
        ratio2_q <= reg_wr_data_in[5:0];
      if (reg_addr_in == `HRD_OFS_RATIO5 &&
          reg_wr_data_in >= 16'(`HRD_RATIO_MIN) &&
          reg_wr_data_in <= 16'(`HRD_RATIO_MAX))
        ratio5_q <= reg_wr_data_in[5:0];
      if (wr_xlimit && reg_wr_data_in >= `HRD_XLIMIT_MIN &&
          reg_wr_data_in <= `HRD_XLIMIT_MAX)
        xlimit_q <= reg_wr_data_in;
      if (reg_addr_in == `HRD_OFS_REF_CUR && reg_wr_data_in != 16'h0000)
        ref_cur_q <= reg_wr_data_in;
      if (reg_addr_in == `HRD_OFS_MIN_DIFF)
        min_diff_q <= reg_wr_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Tick dividers
  // ----------------------------------------------------------------
  logic [15:0] ms_div_q;
  logic        ms_tick_q;
  logic [15:0] cyc_div_q;
  logic        cyc_tick_q;
  logic [15:0] cyc_period;

  // Cycle tick is 1 ms at 50 Hz and 5/6 ms at 60 Hz, so fixed tick
  // counts give both sets of times without a second table
  assign cyc_period = freq60_q ? 16'(CYC60_TICK_CYCLES)
                               : 16'(MS_TICK_CYCLES);

  // Millisecond tick for the cross-block limit
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      ms_div_q  <= 16'h0000;
      ms_tick_q <= 1'b0;
    end
    else
    begin
      ms_tick_q <= (ms_div_q == 16'(MS_TICK_CYCLES - 1));
      ms_div_q  <= (ms_div_q == 16'(MS_TICK_CYCLES - 1)) ? 16'h0000
                                                         : ms_div_q + 16'h0001;
    end
  end

  // Frequency-scaled tick for pickup, drop-off and inrush timers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      cyc_div_q  <= 16'h0000;
      cyc_tick_q <= 1'b0;
    end
    else
    begin
      cyc_tick_q <= (cyc_div_q >= cyc_period - 16'h0001);
      cyc_div_q  <= (cyc_div_q >= cyc_period - 16'h0001) ? 16'h0000
                                                         : cyc_div_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Magnitude stage
  // ----------------------------------------------------------------
  logic [8:0][15:0] mag_q;

  for (genvar m = 0; m < 9; m++)
  begin : g_mag
    // One estimate per current each clock
    always_ff @(posedge sys_clk_in)
    begin
      if (!rst_b_in)
        mag_q[m] <= 16'h0000;
      else
        mag_q[m] <= mag_est(sample_re_in[m], sample_im_in[m]);
    end
  end

  // ----------------------------------------------------------------
  // External fault and inrush conditions
  // ----------------------------------------------------------------
  logic [2:0]  ext_phase;
  logic        ext_fault_q;
  logic        inrush_q;
  logic [12:0] inrush_cnt_q;
  logic [2:0]  cur_present;
  logic [2:0]  det2;

  for (genvar p = 0; p < 3; p++)
  begin : g_angle
    logic [8:0] d;
    logic [8:0] dw;
    assign d  = (side1_angle_in[p] >= side2_angle_in[p])
              ? side1_angle_in[p] - side2_angle_in[p]
              : side2_angle_in[p] - side1_angle_in[p];
    assign dw = (d > 9'd180) ? 9'd360 - d : d;
    // Angle is only meaningful with both sides carrying current
    assign ext_phase[p] = above_pct(mag_q[3 + p], ref_cur_q,
                                    `HRD_VALID_PCT) &&
                          above_pct(mag_q[6 + p], ref_cur_q,
                                    `HRD_VALID_PCT) &&
                          (dw >= `HRD_EXT_ANGLE_DEG);
    assign cur_present[p] = above_pct(mag_q[3 + p], ref_cur_q,
                                      `HRD_INRUSH_PCT) ||
                            above_pct(mag_q[6 + p], ref_cur_q,
                                      `HRD_INRUSH_PCT);
  end

  // External fault condition
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      ext_fault_q <= 1'b0;
    else
      ext_fault_q <= |ext_phase;
  end

  // Inrush condition: set while de-energised, dropped after the delay
  // once current flows with no second harmonic present
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      inrush_q     <= 1'b1;
      inrush_cnt_q <= 13'h0000;
    end
    else if (!(|cur_present) || (|det2))
    begin
      inrush_q     <= inrush_q | ~(|cur_present);
      inrush_cnt_q <= 13'h0000;
    end
    else if (inrush_q && cyc_tick_q)
    begin
      if (inrush_cnt_q + 13'h0001 >= `HRD_INRUSH_TICKS)
        inrush_q <= 1'b0;
      inrush_cnt_q <= inrush_cnt_q + 13'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Restraint elements: 0-2 second harmonic, 3-5 fifth harmonic
  // ----------------------------------------------------------------
  hrd_pkg::hrd_elem_state_type st_q [6];
  logic [4:0]                  tmr_q [6];
  logic [5:0]                  high;
  logic [5:0]                  active;

  for (genvar e = 0; e < 6; e++)
  begin : g_elem
    localparam int P = e % 3;
    if (e < 3)
    begin : g_second
      assign high[e] = ratio_high(second_mag_in[P], fund_mag_in[P],
                                  ratio2_q);
    end
    else
    begin : g_fifth
      assign high[e] = ratio_high(fifth_mag_in[P], fund_mag_in[P],
                                  ratio5_q) &&
                       (mag_q[P] >= min_diff_q);
    end
    assign active[e] = (st_q[e] != hrd_pkg::HRD_IDLE);

    // Pickup must be unbroken; a dip before it clears the timer
    always_ff @(posedge sys_clk_in)
    begin
      if (!rst_b_in)
      begin
        st_q[e]  <= hrd_pkg::HRD_IDLE;
        tmr_q[e] <= 5'h00;
      end
      else
      begin
        case (st_q[e])
          hrd_pkg::HRD_IDLE:
            if (high[e])
            begin
              st_q[e]  <= hrd_pkg::HRD_PICKUP;
              tmr_q[e] <= 5'h00;
            end
          hrd_pkg::HRD_PICKUP:
            if (!high[e])
              st_q[e] <= hrd_pkg::HRD_IDLE;
            else if (cyc_tick_q)
            begin
              if (tmr_q[e] + 5'h01 >= `HRD_PICKUP_TICKS)
                st_q[e] <= hrd_pkg::HRD_HELD;
              tmr_q[e] <= tmr_q[e] + 5'h01;
            end
          hrd_pkg::HRD_HELD:
            if (!high[e])
            begin
              st_q[e]  <= hrd_pkg::HRD_DROP;
              tmr_q[e] <= 5'h00;
            end
          hrd_pkg::HRD_DROP:
            if (high[e])
              st_q[e] <= hrd_pkg::HRD_HELD;
            else if (cyc_tick_q)
            begin
              if (tmr_q[e] + 5'h01 >= `HRD_DROP_TICKS)
                st_q[e] <= hrd_pkg::HRD_IDLE;
              tmr_q[e] <= tmr_q[e] + 5'h01;
            end
          default:
            st_q[e] <= hrd_pkg::HRD_IDLE;
        endcase
      end
    end
  end

  assign det2 = active[2:0];

  // ----------------------------------------------------------------
  // Gating, summaries and cross blocking
  // ----------------------------------------------------------------
  logic [2:0]  restr2_q;
  logic [2:0]  restr5_q;
  logic        any2_q;
  logic        any5_q;
  logic        xblk_q;
  logic [15:0] xcnt_q;
  logic [2:0]  block_q;
  logic [2:0]  det2_q;
  logic [2:0]  gated2;
  logic        xrun;
  logic        xblk_d;

  // Second harmonic only restrains while a condition asks for it
  assign gated2 = det2 & {3{inrush_q | ext_fault_q}};

  // Next cross-block state, shared by the flag and the element blocks
  // so that the two never disagree for a cycle
  assign xrun   = xblk_en_q && (|gated2 || |active[5:3]);
  assign xblk_d = xrun && (xcnt_q < xlimit_q);

  // Per-phase and summary restraint flags
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      det2_q   <= 3'h0;
      restr2_q <= 3'h0;
      restr5_q <= 3'h0;
      any2_q   <= 1'b0;
      any5_q   <= 1'b0;
    end
    else
    begin
      det2_q   <= det2;
      restr2_q <= gated2;
      restr5_q <= active[5:3];
      any2_q   <= |gated2;
      any5_q   <= |active[5:3];
    end
  end

  // Cross blocking timer; after expiry it stays off until all restraint
  // clears, so a long inrush cannot hold healthy phases blocked
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      xblk_q <= 1'b0;
      xcnt_q <= 16'h0000;
    end
    else if (!xrun)
    begin
      xblk_q <= 1'b0;
      xcnt_q <= 16'h0000;
    end
    else
    begin
      xblk_q <= xblk_d;
      if (xblk_d && ms_tick_q)
        xcnt_q <= xcnt_q + 16'h0001;
    end
  end

  // Element blocking: own restraint always, others only while crossing
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      block_q <= 3'h0;
    else
      block_q <= gated2 | active[5:3] |
                 {3{xblk_d}};
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [15:0] rd_q;

  // Data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      rd_q <= 16'h0000;
    else if (!reg_rd_in)
      rd_q <= 16'h0000;
    else
    begin
      case (reg_addr_in)
        `HRD_OFS_CTRL:     rd_q <= {14'h0000, freq60_q, xblk_en_q};
        `HRD_OFS_RATIO2:   rd_q <= {10'h000, ratio2_q};
        `HRD_OFS_RATIO5:   rd_q <= {10'h000, ratio5_q};
        `HRD_OFS_XLIMIT:   rd_q <= xlimit_q;
        `HRD_OFS_REF_CUR:  rd_q <= ref_cur_q;
        `HRD_OFS_MIN_DIFF: rd_q <= min_diff_q;
        `HRD_OFS_STATUS:   rd_q <= {1'b0, xblk_q, ext_fault_q, inrush_q,
                                    block_q, restr5_q, restr2_q, det2_q};
        default:           rd_q <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rd_data_out                         = rd_q;
  assign current_mag_out                         = mag_q;
  assign second_harmonic_detect_out              = det2_q;
  assign second_harmonic_restraint_out           = restr2_q;
  assign any_phase_second_harmonic_restraint_out = any2_q;
  assign fifth_harmonic_restraint_out            = restr5_q;
  assign any_phase_fifth_harmonic_restraint_out  = any5_q;
  assign element_block_out                       = block_q;
  assign cross_block_active_out                  = xblk_q;
  assign inrush_condition_out                    = inrush_q;
  assign external_fault_out                      = ext_fault_q;

endmodule

// >>> bench/hrd_meas_model.sv
// Upstream harmonic measurement model for the restraint bench
`timescale 1ns/10ps
module hrd_meas_model
(
  // Clock and requested harmonic content
  input  wire logic            clk_in,
  input  wire logic [15:0]     fund_in,
  input  wire logic [2:0][7:0] pct2_in,
  input  wire logic [2:0][7:0] pct5_in,
  // Fourier magnitudes per phase
  output logic [2:0][15:0]     fund_out,
  output logic [2:0][15:0]     second_out,
  output logic [2:0][15:0]     fifth_out
);
  // One sample of filter delay; truncation keeps an exact ratio low
  always_ff @(posedge clk_in)
  begin
    for (int p = 0; p < 3; p++)
    begin
      fund_out[p]   <= fund_in;
      second_out[p] <= 16'(32'(fund_in) * pct2_in[p] / 100);
      fifth_out[p]  <= 16'(32'(fund_in) * pct5_in[p] / 100);
    end
  end
endmodule

// >>> bench/hrd_restraint_props.sv
// Port-level assertions for the harmonic restraint block
`timescale 1ns/10ps
module hrd_restraint_props
(
  // Clock and reset
  input wire logic             sys_clk_in,
  input wire logic             rst_b_in,
  // Magnitudes
  input wire logic [2:0][15:0] fund_mag_in,
  input wire logic [2:0][15:0] second_mag_in,
  // Status
  input wire logic [2:0]       second_harmonic_detect_out,
  input wire logic [2:0]       second_harmonic_restraint_out,
  input wire logic             any_phase_second_harmonic_restraint_out,
  input wire logic [2:0]       fifth_harmonic_restraint_out,
  input wire logic             any_phase_fifth_harmonic_restraint_out,
  input wire logic [2:0]       element_block_out,
  input wire logic             cross_block_active_out,
  input wire logic             inrush_condition_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // Restraint each element raises for itself
  logic [2:0] own;
  assign own = second_harmonic_restraint_out | fifth_harmonic_restraint_out;
  // More than half the fundamental beats any legal ratio setting
  sequence s_ratio_high;
    fund_mag_in[0] != 16'h0000 &&
    32'(second_mag_in[0]) * 100 > 32'(fund_mag_in[0]) * 50;
  endsequence
  sequence s_detect_late;
    ##2 second_harmonic_detect_out[0];
  endsequence
  a_ratio_detect: assert property (
    s_ratio_high |-> s_detect_late) else $error("high ratio missed");
  a_any_second: assert property (
    any_phase_second_harmonic_restraint_out ==
    |second_harmonic_restraint_out) else $error("second summary wrong");
  a_any_fifth: assert property (
    any_phase_fifth_harmonic_restraint_out ==
    |fifth_harmonic_restraint_out) else $error("fifth summary wrong");
  a_gate_subset: assert property (
    (second_harmonic_restraint_out & ~second_harmonic_detect_out) == 3'h0)
    else $error("restraint without detect");
  a_inrush_gate: assert property (
    $past(inrush_condition_out) |->
    second_harmonic_restraint_out == second_harmonic_detect_out)
    else $error("inrush gating wrong");
  a_self_block: assert property (
    (own & ~element_block_out) == 3'h0) else $error("own block missing");
  a_cross_all: assert property (
    cross_block_active_out |-> element_block_out == 3'h7)
    else $error("cross block partial");
  a_cross_end: assert property (
    !cross_block_active_out |-> element_block_out == own)
    else $error("block without cause");
  a_inrush_start: assert property (
    $rose(rst_b_in) |-> inrush_condition_out) else $error("inrush low");
endmodule
bind hrd_restraint hrd_restraint_props u_props (.sys_clk_in, .rst_b_in,
  .fund_mag_in, .second_mag_in, .second_harmonic_detect_out,
  .second_harmonic_restraint_out, .any_phase_second_harmonic_restraint_out,
  .fifth_harmonic_restraint_out, .any_phase_fifth_harmonic_restraint_out,
  .element_block_out, .cross_block_active_out, .inrush_condition_out);

// >>> bench/testbench.sv
// Self-checking bench for the harmonic restraint decision block
`timescale 1ns/10ps
`include "hrd_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module testbench;
  logic             clk, rst_b, wr, rd;
  logic [7:0]       addr;
  logic [15:0]      wdata, rdata, fund;
  logic [8:0][15:0] sre, sim, mag;
  logic [2:0][15:0] fm, sm, vm;
  logic [2:0][8:0]  a1, a2;
  logic [2:0][7:0]  p2, p5;
  logic [2:0]       det, r2, r5, blk;
  logic             any2, any5, xb, inr, ext;
  logic [31:0]      seed;
  int               n_fail, compares;
  // Tables, highest index first
  localparam logic [6:0][7:0] ofs = {8'h1c, `HRD_OFS_MIN_DIFF,
    `HRD_OFS_REF_CUR, `HRD_OFS_XLIMIT, `HRD_OFS_RATIO5, `HRD_OFS_RATIO2,
    `HRD_OFS_CTRL};
  localparam logic [6:0][15:0] dft = {16'h0000, 16'h0080, 16'h0400,
    16'h1388, 16'h0019, 16'h000f, 16'h0001};
  localparam logic [3:0][15:0] xw = {16'h0064, 16'hea60, 16'hea61, 16'h0063};
  localparam logic [3:0][15:0] xe = {16'h0064, 16'hea60, 16'h1388, 16'h1388};
  localparam logic [5:0][8:0] g1 = {9'h0, 9'h0, 9'h00a, 9'h15e, 9'h0, 9'h0};
  localparam logic [5:0][8:0] g2 = {{2{9'h04b}}, 9'h12c, 9'h041, 9'h04a,
    9'h04b};
  localparam logic [5:0][15:0] gm = {16'h0067, 16'h0066, {4{16'h0100}}};
  hrd_meas_model src (.clk_in(clk), .fund_in(fund), .pct2_in(p2),
    .pct5_in(p5), .fund_out(fm), .second_out(sm), .fifth_out(vm));
  // Short ticks keep the long timers within a brief run
  hrd_restraint #(.MS_TICK_CYCLES(20), .CYC60_TICK_CYCLES(16)) dut (
    .sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
    .reg_wr_data_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rd_data_out(rdata), .sample_re_in(sre), .sample_im_in(sim),
    .fund_mag_in(fm), .second_mag_in(sm), .fifth_mag_in(vm),
    .side1_angle_in(a1), .side2_angle_in(a2), .current_mag_out(mag),
    .second_harmonic_detect_out(det), .second_harmonic_restraint_out(r2),
    .any_phase_second_harmonic_restraint_out(any2),
    .fifth_harmonic_restraint_out(r5),
    .any_phase_fifth_harmonic_restraint_out(any5),
    .element_block_out(blk), .cross_block_active_out(xb),
    .inrush_condition_out(inr), .external_fault_out(ext));
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Samples stay within 15 bits, so no saturation is expected
  function automatic logic [15:0] emag(input logic [15:0] re, im);
    logic [15:0] x, y;
    x = re[15] ? -re : re;
    y = im[15] ? -im : im;
    return (x > y) ? x + (y >> 1) : y + (x >> 1);
  endfunction
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  // A long high ratio leaves a drop-off tail of fifteen ticks
  task automatic tail(input int t);
    @(posedge clk);
    p2[0] <= 8'd60;
    nap(27 * t);
    @(posedge clk);
    p2[0] <= 8'd0;
    nap(14 * t);
    `CHK(det[0], 1'b1)
    nap(3 * t);
    `CHK(det[0], 1'b0)
  endtask
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial
  begin
    #(20000 * 25);
    n_fail++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  initial
  begin
    {rst_b, wr, rd, addr, wdata, sre, sim, a1, a2, p2, p5} = '0;
    {n_fail, compares} = '0;
    fund = 16'h03e8;
    seed = 32'ha037bb77;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++)
      rchk(ofs[i], dft[i]);
    wreg(`HRD_OFS_RATIO2, 16'h0004);
    rchk(`HRD_OFS_RATIO2, 16'h000f);
    for (int i = 0; i < 4; i++)
    begin
      wreg(`HRD_OFS_XLIMIT, xw[i]);
      rchk(`HRD_OFS_XLIMIT, xe[i]);
    end
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
        seed = lfsr(seed);
        sre[i] <= {seed[14], seed[14:0]};
        sim[i] <= {seed[30], seed[30:16]};
      end
      nap(1);
      for (int i = 0; i < 9; i++)
        `CHK(mag[i], emag(sre[i], sim[i]))
    end
    @(posedge clk);
    {sre, sim} <= '0;
    p2[1] <= 8'd15;
    nap(6);
    `CHK(det, 3'h0)
    @(posedge clk);
    p2[1] <= 8'd16;
    nap(5);
    `CHK({inr, det, r2, any2, blk}, 11'h52f)
    rchk(`HRD_OFS_STATUS, 16'h5e12);
    @(posedge clk);
    p2[1] <= 8'd0;
    nap(5);
    `CHK(det, 3'h0)
    tail(20);
    wreg(`HRD_OFS_CTRL, 16'h0003);
    tail(16);
    wreg(`HRD_OFS_CTRL, 16'h0001);
    nap(400);
    @(posedge clk);
    sre[2] <= 16'h1000;
    p5[2] <= 8'd30;
    nap(5);
    `CHK({r5, any5, blk, xb}, 8'h9f)
    nap(1940);
    `CHK(xb, 1'b1)
    nap(80);
    `CHK({blk, xb}, 4'h8)
    @(posedge clk);
    sre[2] <= 16'h0010;
    p5[2] <= 8'd0;
    nap(400);
    @(posedge clk);
    p5[2] <= 8'd30;
    nap(5);
    `CHK(r5, 3'h0)
    wreg(`HRD_OFS_CTRL, 16'h0000);
    @(posedge clk);
    sre[2] <= 16'h1000;
    nap(5);
    `CHK({blk, xb}, 4'h8)
    @(posedge clk);
    sre <= {{6{16'h0100}}, 48'h0};
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      sre[6] <= gm[i];
      a1[0] <= g1[i];
      a2[0] <= g2[i];
      nap(4);
      `CHK(ext, 6'h25 >> i & 6'h01)
    end
    wrap_up();
  end
endmodule
